// ==== sal_panel_model.sv ====
module sal_panel_model #(
    parameter int TICK  = 20,
    parameter int PRESS = 3
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] key_req,
    output logic            sec_tick,
    output logic      [3:0] manual_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    int tick_cnt;
    int hold_cnt;
    // Free running meter second, shortened to TICK cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn) tick_cnt <= 0;
        else tick_cnt <= (tick_cnt == TICK - 1) ? 0 : tick_cnt + 1;
    end
    assign sec_tick = (tick_cnt == TICK - 1);
    // Key or user input held for a short momentary press
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn) manual_reset <= 4'h0;
        else if (|key_req) manual_reset <= key_req;
        else if (hold_cnt == 0) manual_reset <= 4'h0;
        if (!presetn) hold_cnt <= 0;
        else hold_cnt <= (|key_req) ? PRESS : (hold_cnt > 0 ? hold_cnt - 1 : 0);
    end
endmodule

// ==== sal_pkg.sv ====
package sal_pkg;

    // Setpoint count and register map
    localparam int         NUM_SP     = 4;
    localparam logic [4:0] OFS_CFG    = 5'h00;
    localparam logic [4:0] OFS_VALUE  = 5'h04;
    localparam logic [4:0] OFS_BAND   = 5'h08;
    localparam logic [4:0] OFS_HYST   = 5'h0C;
    localparam logic [4:0] OFS_ONDLY  = 5'h10;
    localparam logic [4:0] OFS_OFFDLY = 5'h14;
    localparam logic [7:0] OFS_STATUS = 8'h80;
    localparam logic [7:0] OFS_CMD    = 8'h84;

    // Accepted ranges of programmed values
    localparam logic signed [31:0] VALUE_MIN   = -32'sd199999;
    localparam logic signed [31:0] VALUE_MAX   = 32'sd999999;
    localparam logic [15:0]        HYST_MIN    = 16'd1;
    localparam logic [15:0]        HYST_MAX    = 16'd65000;
    localparam logic [14:0]        ON_DLY_MAX  = 15'd32150;
    localparam logic [14:0]        OFF_DLY_MAX = 15'd32750;
    localparam logic [29:0]        TOT_SPLIT   = 30'd1000000;
    localparam logic [29:0]        TOT_HI_DIV  = 30'd1000;

    // Reset values
    localparam logic [15:0] HYST_RST = 16'h0001;

    typedef enum logic [1:0] {
        SRC_NONE         = 2'b00,
        NET_VALUE_SOURCE = 2'b01,
        SRC_GROSS        = 2'b10,
        SRC_TOTAL        = 2'b11
    } sal_src_type;

    typedef enum logic [3:0] {
        ACT_NONE               = 4'b0000,
        ACT_ABS_HI_BAL         = 4'b0001,
        ACT_ABS_LO_BAL         = 4'b0010,
        ACT_ABS_HI_UNB         = 4'b0011,
        ACT_ABS_LO_UNB         = 4'b0100,
        ACT_DEV_HI             = 4'b0101,
        ACT_DEV_LO             = 4'b0110,
        ACT_OUTSIDE_BAND       = 4'b0111,
        INSIDE_WINDOW_ACTION   = 4'b1000,
        ACT_TOTAL_LOW_HALF     = 4'b1001,
        TOTAL_HIGH_HALF_ACTION = 4'b1010
    } sal_act_type;

    typedef enum logic [1:0] {
        RST_AUTO        = 2'b00,
        RST_LATCH_NOW   = 2'b01,
        RST_LATCH_DELAY = 2'b10
    } sal_rst_type;

    typedef enum logic [1:0] {
        ANN_NORMAL  = 2'b00,
        ANN_INVERSE = 2'b01,
        ANN_FLASH   = 2'b10,
        ANN_OFF     = 2'b11
    } sal_ann_type;

    // Per-setpoint configuration word, bit 0 upward: src, action, polarity, reset, standby
    typedef struct packed {
        logic [2:0]  color;
        sal_ann_type ann;
        logic        standby;
        sal_rst_type rst_mode;
        logic        inverted_polarity;
        sal_act_type action;
        sal_src_type src;
    } sal_cfg_type;

    typedef struct packed {
        logic [3:0] alarm;
        logic [3:0] out;
    } sal_status_type;

endpackage

// ==== sal_setpoint_alarm.sv ====
// Overview of operation
// - All four setpoints are configured and evaluated whatever outputs are fitted.
// - Net source is gross plus tare offset; gross source is gross alone.
// - Totalizer actions work only when the source is the totalizer.
// - Actions: none, absolute balanced/unbalanced, deviation, outside and inside band.
// - Totalizer actions compare low or high six digits, unbalanced hysteresis.
// - Setpoint value accepted only from -199999 to 999999.
// - Band value used by band/deviation only; negative refused for band actions.
// - Hysteresis accepted only from 1 to 65000.
// - Unbalanced hysteresis lies below high trips and above low trips.
// - Alarm assertion waits the on-delay; zero means next evaluation.
// - Alarm release waits the off-delay, up to 32750 seconds.
// - With inverted polarity the delays follow the alarm, not the output level.
// - Partial delay timing is cleared at power-up.
// - Polarity passes the alarm to the output as is or inverted.
// - Auto reset follows trips; manual reset clears until the next crossing.
// - Immediate latch holds until manual or serial reset or power cycle.
// - Delayed latch stores the reset and applies it at trigger-off.
// - Power-up drops pending delayed resets; latched alarms start off.
// - Standby suppresses the alarm until the trigger is first crossed.
// - Annunciator: on, inverse, flashing on, or disabled.
// - Highest numbered active alarm with a colour sets the display colour.
module sal_setpoint_alarm (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               ce,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic        [7:0]  paddr,
    input  wire logic        [31:0] pwdata,
    output logic             [31:0] prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic signed [31:0] gross_value,
    input  wire logic signed [31:0] tare_offset,
    input  wire logic        [29:0] total_value,
    input  wire logic               sample_strobe,
    input  wire logic               sec_tick,
    input  wire logic        [3:0]  manual_reset,
    output logic             [3:0]  alarm_out,
    output logic             [3:0]  annunciator,
    output logic             [2:0]  color_override
);

    sal_pkg::sal_cfg_type    cfg_reg    [sal_pkg::NUM_SP];
    logic signed [31:0]      value_reg  [sal_pkg::NUM_SP];
    logic signed [31:0]      band_reg   [sal_pkg::NUM_SP];
    logic        [15:0]      hyst_reg   [sal_pkg::NUM_SP];
    logic        [14:0]      on_dly_reg [sal_pkg::NUM_SP];
    logic        [14:0]      off_dly_reg[sal_pkg::NUM_SP];
    logic        [31:0]      rd_data;
    logic                    addr_ok;
    logic                    wr_ok;
    logic                    wr_en;
    logic        [1:0]       sel_sp;
    logic        [3:0]       ser_rst_reg;
    logic                    eval1_reg;
    logic                    eval2_reg;
    logic                    blink_reg;
    logic        [3:0]       alarm_vec;
    logic        [3:0]       out_vec;
    logic        [2:0]       color_next;
    logic                    pready_reg;
    logic        [31:0]      prdata_reg;
    logic                    pslverr_reg;
    logic        [3:0]       out_reg;
    logic        [3:0]       ann_reg;
    logic        [2:0]       color_reg;
    logic signed [31:0]      net_value;
    logic signed [31:0]      tot_low;
    logic signed [31:0]      tot_high;
    sal_pkg::sal_status_type status;

    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = pslverr_reg;
    assign alarm_out      = out_reg;
    assign annunciator    = ann_reg;
    assign color_override = color_reg;
    assign status         = '{alarm: alarm_vec, out: out_vec};

    // Meter values offered to the setpoints
    assign net_value = gross_value + tare_offset;
    assign tot_low   = {2'b00, total_value % sal_pkg::TOT_SPLIT};
    assign tot_high  = {2'b00, total_value / sal_pkg::TOT_HI_DIV};

    // Address decode, read mux and write acceptance
    always_comb
    begin
        sel_sp  = paddr[6:5];
        rd_data = 32'h0000_0000;
        addr_ok = 1'b1;
        wr_ok   = 1'b1;
        if (paddr[7] == 1'b0)
        begin
            if (paddr[4:0] == sal_pkg::OFS_CFG)
                rd_data = {17'h00000, cfg_reg[sel_sp]};
            else if (paddr[4:0] == sal_pkg::OFS_VALUE)
            begin
                rd_data = value_reg[sel_sp];
                wr_ok   = ($signed(pwdata) >= sal_pkg::VALUE_MIN)
                          && ($signed(pwdata) <= sal_pkg::VALUE_MAX);
            end
            else if (paddr[4:0] == sal_pkg::OFS_BAND)
            begin
                rd_data = band_reg[sel_sp];
                wr_ok   = ($signed(pwdata) >= sal_pkg::VALUE_MIN)
                          && ($signed(pwdata) <= sal_pkg::VALUE_MAX);
                if (pwdata[31] && ((cfg_reg[sel_sp].action == sal_pkg::ACT_OUTSIDE_BAND)
                    || (cfg_reg[sel_sp].action == sal_pkg::INSIDE_WINDOW_ACTION)))
                    wr_ok = 1'b0;
            end
            else if (paddr[4:0] == sal_pkg::OFS_HYST)
            begin
                rd_data = {16'h0000, hyst_reg[sel_sp]};
                wr_ok   = (pwdata >= 32'(sal_pkg::HYST_MIN))
                          && (pwdata <= 32'(sal_pkg::HYST_MAX));
            end
            else if (paddr[4:0] == sal_pkg::OFS_ONDLY)
            begin
                rd_data = {17'h00000, on_dly_reg[sel_sp]};
                wr_ok   = pwdata <= 32'(sal_pkg::ON_DLY_MAX);
            end
            else if (paddr[4:0] == sal_pkg::OFS_OFFDLY)
            begin
                rd_data = {17'h00000, off_dly_reg[sel_sp]};
                wr_ok   = pwdata <= 32'(sal_pkg::OFF_DLY_MAX);
            end
            else
                addr_ok = 1'b0;
        end
        else if (paddr == sal_pkg::OFS_STATUS)
        begin
            rd_data = {24'h000000, status};
            wr_ok   = 1'b0;
        end
        else if (paddr == sal_pkg::OFS_CMD)
            rd_data = 32'h0000_0000;
        else
            addr_ok = 1'b0;
    end

    assign wr_en = ce && psel && penable && pwrite && pready_reg && addr_ok && wr_ok;

    // APB answer: data and error are prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else if (ce)
        begin
            pready_reg <= 1'b1;
            if (psel && !penable)
            begin
                prdata_reg  <= pwrite ? 32'h0000_0000 : rd_data;
                pslverr_reg <= !addr_ok || (pwrite && !wr_ok);
            end
        end
    end

    // Configuration storage, kept for all setpoints
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int k = 0; k < sal_pkg::NUM_SP; k++)
            begin
                cfg_reg[k]     <= '0;
                value_reg[k]   <= 32'sh0000_0000;
                band_reg[k]    <= 32'sh0000_0000;
                hyst_reg[k]    <= sal_pkg::HYST_RST;
                on_dly_reg[k]  <= 15'h0000;
                off_dly_reg[k] <= 15'h0000;
            end
        end
        else if (wr_en && (paddr[7] == 1'b0))
        begin
            if (paddr[4:0] == sal_pkg::OFS_CFG)
                cfg_reg[sel_sp] <= pwdata[14:0];
            else if (paddr[4:0] == sal_pkg::OFS_VALUE)
                value_reg[sel_sp] <= pwdata;
            else if (paddr[4:0] == sal_pkg::OFS_BAND)
                band_reg[sel_sp] <= pwdata;
            else if (paddr[4:0] == sal_pkg::OFS_HYST)
                hyst_reg[sel_sp] <= pwdata[15:0];
            else if (paddr[4:0] == sal_pkg::OFS_ONDLY)
                on_dly_reg[sel_sp] <= pwdata[14:0];
            else
                off_dly_reg[sel_sp] <= pwdata[14:0];
        end
    end

    // Serial reset command pulses and evaluation pipeline strobes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ser_rst_reg <= 4'h0;
            eval1_reg   <= 1'b0;
            eval2_reg   <= 1'b0;
            blink_reg   <= 1'b0;
        end
        else if (ce)
        begin
            ser_rst_reg <= (wr_en && (paddr == sal_pkg::OFS_CMD)) ? pwdata[3:0] : 4'h0;
            eval1_reg   <= sample_strobe;
            eval2_reg   <= eval1_reg;
            if (sec_tick)
                blink_reg <= !blink_reg;
        end
    end

    for (genvar i = 0; i < sal_pkg::NUM_SP; i++)
    begin : g_sp
        sal_pkg::sal_cfg_type c;
        logic signed [31:0]   v;
        logic signed [31:0]   thr;
        logic signed [31:0]   h;
        logic signed [31:0]   hh;
        logic                 on_c;
        logic                 off_c;
        logic                 trip_next;
        logic                 trip_reg;
        logic                 seen_off_reg;
        logic                 target_reg;
        logic                 dly_reg;
        logic [14:0]          cnt_reg;
        logic [14:0]          lim;
        logic                 alarm_reg;
        logic                 held_reg;
        logic                 pend_reg;
        logic                 rst_ev;

        assign c      = cfg_reg[i];
        assign h      = {16'h0000, hyst_reg[i]};
        assign hh     = h >>> 1;
        assign rst_ev = manual_reset[i] || ser_rst_reg[i];
        assign lim    = target_reg ? on_dly_reg[i] : off_dly_reg[i];

        // Trip and release conditions of the selected action
        always_comb
        begin
            case (c.src)
                sal_pkg::NET_VALUE_SOURCE: v = net_value;
                sal_pkg::SRC_GROSS:        v = gross_value;
                sal_pkg::SRC_TOTAL:        v = {2'b00, total_value};
                default:                   v = 32'sh0000_0000;
            endcase
            thr   = value_reg[i];
            on_c  = 1'b0;
            off_c = 1'b1;
            case (c.action)
                sal_pkg::ACT_ABS_HI_BAL:
                begin
                    on_c  = v >= thr + hh;
                    off_c = v <= thr - hh;
                end
                sal_pkg::ACT_ABS_LO_BAL:
                begin
                    on_c  = v <= thr - hh;
                    off_c = v >= thr + hh;
                end
                sal_pkg::ACT_ABS_HI_UNB, sal_pkg::ACT_DEV_HI:
                begin
                    if (c.action == sal_pkg::ACT_DEV_HI)
                        thr = thr + band_reg[i];
                    on_c  = v >= thr;
                    off_c = v <= thr - h;
                end
                sal_pkg::ACT_ABS_LO_UNB, sal_pkg::ACT_DEV_LO:
                begin
                    if (c.action == sal_pkg::ACT_DEV_LO)
                        thr = thr - band_reg[i];
                    on_c  = v <= thr;
                    off_c = v >= thr + h;
                end
                sal_pkg::ACT_OUTSIDE_BAND:
                begin
                    on_c  = (v >= thr + band_reg[i]) || (v <= thr - band_reg[i]);
                    off_c = (v < thr + band_reg[i] - h) && (v > thr - band_reg[i] + h);
                end
                sal_pkg::INSIDE_WINDOW_ACTION:
                begin
                    on_c  = (v <= thr + band_reg[i]) && (v >= thr - band_reg[i]);
                    off_c = (v > thr + band_reg[i] + h) || (v < thr - band_reg[i] - h);
                end
                sal_pkg::ACT_TOTAL_LOW_HALF, sal_pkg::TOTAL_HIGH_HALF_ACTION:
                begin
                    if (c.src == sal_pkg::SRC_TOTAL)
                    begin
                        v     = (c.action == sal_pkg::ACT_TOTAL_LOW_HALF) ? tot_low : tot_high;
                        on_c  = v >= thr;
                        off_c = v <= thr - h;
                    end
                end
                default:
                begin
                    on_c  = 1'b0;
                    off_c = 1'b1;
                end
            endcase
            trip_next = on_c ? 1'b1 : (off_c ? 1'b0 : trip_reg);
        end

        // Hysteresis state and standby gate, once per measurement
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                trip_reg     <= 1'b0;
                seen_off_reg <= 1'b0;
                target_reg   <= 1'b0;
            end
            else if (ce && sample_strobe)
            begin
                trip_reg <= trip_next;
                if (!trip_next)
                    seen_off_reg <= 1'b1;
                target_reg <= trip_next && (!c.standby || seen_off_reg || !trip_next);
            end
        end

        // On and off delays counted in meter seconds
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                dly_reg <= 1'b0;
                cnt_reg <= 15'h0000;
            end
            else if (ce)
            begin
                if (target_reg == dly_reg)
                    cnt_reg <= 15'h0000;
                else if (eval1_reg && (cnt_reg >= lim))
                begin
                    dly_reg <= target_reg;
                    cnt_reg <= 15'h0000;
                end
                else if (sec_tick && (cnt_reg < lim))
                    cnt_reg <= cnt_reg + 15'h0001;
            end
        end

        // Reset behaviour: automatic, immediate latch, delayed latch
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                alarm_reg <= 1'b0;
                held_reg  <= 1'b0;
                pend_reg  <= 1'b0;
            end
            else if (ce)
            begin
                if (c.rst_mode == sal_pkg::RST_LATCH_DELAY)
                begin
                    if (eval2_reg && !dly_reg && alarm_reg && (pend_reg || rst_ev))
                    begin
                        alarm_reg <= 1'b0;
                        pend_reg  <= 1'b0;
                    end
                    else
                    begin
                        if (rst_ev && alarm_reg)
                            pend_reg <= 1'b1;
                        if (eval2_reg && dly_reg)
                            alarm_reg <= 1'b1;
                    end
                end
                else if (rst_ev && alarm_reg)
                begin
                    alarm_reg <= 1'b0;
                    held_reg  <= dly_reg;
                end
                else if (eval2_reg)
                begin
                    if (!dly_reg)
                        held_reg <= 1'b0;
                    if (c.rst_mode == sal_pkg::RST_LATCH_NOW)
                    begin
                        if (dly_reg && !held_reg)
                            alarm_reg <= 1'b1;
                    end
                    else
                        alarm_reg <= dly_reg && !held_reg;
                end
                if (c.rst_mode != sal_pkg::RST_LATCH_DELAY)
                    pend_reg <= 1'b0;
            end
        end

        assign alarm_vec[i] = alarm_reg;
        assign out_vec[i]   = alarm_reg ^ c.inverted_polarity;
    end

    // Display colour from the highest numbered active alarm
    always_comb
    begin
        color_next = 3'h0;
        for (int k = 0; k < sal_pkg::NUM_SP; k++)
        begin
            if (alarm_vec[k] && (cfg_reg[k].color != 3'h0))
                color_next = cfg_reg[k].color;
        end
    end

    // Registered outputs, annunciators and colour
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_reg   <= 4'h0;
            ann_reg   <= 4'h0;
            color_reg <= 3'h0;
        end
        else if (ce)
        begin
            out_reg   <= out_vec;
            color_reg <= color_next;
            for (int k = 0; k < sal_pkg::NUM_SP; k++)
            begin
                case (cfg_reg[k].ann)
                    sal_pkg::ANN_NORMAL:  ann_reg[k] <= alarm_vec[k];
                    sal_pkg::ANN_INVERSE: ann_reg[k] <= !alarm_vec[k];
                    sal_pkg::ANN_FLASH:   ann_reg[k] <= alarm_vec[k] && blink_reg;
                    default:              ann_reg[k] <= 1'b0;
                endcase
            end
        end
    end

endmodule

// ==== sal_setpoint_alarm_bench.sv ====
module sal_setpoint_alarm_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0, strobe = 1'b0;
    logic        [7:0]  paddr = 8'h00;
    logic        [31:0] pwdata = 32'h0, prdata, rd;
    logic               pready, pslverr, err, tick;
    logic signed [31:0] gross = 0, tare = 0;
    logic        [29:0] total = 30'h0;
    logic        [3:0]  key = 4'h0, mrst, aout, ann;
    logic        [2:0]  col;
    int                 n_fail = 0, n_compared = 0;
    always #5 pclk = ~pclk;
    sal_setpoint_alarm i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gross_value(gross), .tare_offset(tare),
        .total_value(total), .sample_strobe(strobe), .sec_tick(tick), .manual_reset(mrst),
        .alarm_out(aout), .annunciator(ann), .color_override(col));
    sal_panel_model i_panel (.pclk(pclk), .presetn(presetn), .key_req(key),
        .sec_tick(tick), .manual_reset(mrst));
    // Comparison and verdict
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task test_done;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // APB transfer held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wrc(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        chk("pslverr", {31'h0, err}, {31'h0, e});
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("prdata", rd, exp);
    endtask
    // One measurement update, outputs settled four edges later
    task ev(input logic signed [31:0] g, input logic [3:0] exp);
        @(posedge pclk);
        gross <= g;
        strobe <= 1'b1;
        @(posedge pclk);
        strobe <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("alarm_out", {28'h0, aout}, {28'h0, exp});
    endtask
    task t_regs;
        rdc(8'h0C, 32'h1);
        wrc(8'h24, 32'hFFFCF2C0, 1'b1);
        wrc(8'h24, 32'hFFFCF2C1, 1'b0);
        wrc(8'h48, 32'h000F4240, 1'b1);
        wrc(8'h60, 32'h0000001C, 1'b0);
        wrc(8'h68, 32'hFFFFFFFF, 1'b1);
        wrc(8'h60, 32'h0, 1'b0);
        wrc(8'h2C, 32'h0, 1'b1);
        wrc(8'h2C, 32'h0000FDE9, 1'b1);
        wrc(8'h2C, 32'h0000FDE8, 1'b0);
        rdc(8'h2C, 32'h0000FDE8);
        wrc(8'h30, 32'h00007D97, 1'b1);
        wrc(8'h34, 32'h00007FEF, 1'b1);
        wrc(8'h34, 32'h00007FEE, 1'b0);
        wrc(8'h34, 32'h0, 1'b0);
        wrc(8'h18, 32'h1, 1'b1);
        wrc(8'h80, 32'h1, 1'b1);
        $display("test regs done");
    endtask
    task t_abs;
        wrc(8'h20, 32'h0E, 1'b0);
        wrc(8'h24, 32'h64, 1'b0);
        wrc(8'h2C, 32'h0A, 1'b0);
        ev(99, 4'h0);
        ev(100, 4'h2);
        ev(91, 4'h2);
        ev(90, 4'h0);
        wrc(8'h20, 32'h4E, 1'b0);
        ev(90, 4'h2);
        wrc(8'h20, 32'h0, 1'b0);
        $display("test abs done");
    endtask
    task t_src;
        tare <= 60;
        total <= 30'd1000005;
        wrc(8'h40, 32'h500D, 1'b0);
        wrc(8'h44, 32'h64, 1'b0);
        wrc(8'h60, 32'h3027, 1'b0);
        wrc(8'h64, 32'h05, 1'b0);
        ev(50, 4'hC);
        chk("color", {29'h0, col}, 32'h3);
        wrc(8'h60, 32'h302B, 1'b0);
        wrc(8'h64, 32'h3E8, 1'b0);
        ev(50, 4'hC);
        wrc(8'h60, 32'h302A, 1'b0);
        ev(50, 4'h4);
        chk("color", {29'h0, col}, 32'h5);
        wrc(8'h40, 32'h500E, 1'b0);
        ev(50, 4'h0);
        wrc(8'h40, 32'h0, 1'b0);
        $display("test src done");
    endtask
    task t_latch;
        wrc(8'h00, 32'h8E, 1'b0);
        wrc(8'h04, 32'h64, 1'b0);
        ev(120, 4'h1);
        chk("annunciator", {28'h0, ann}, 32'h1);
        ev(50, 4'h1);
        wrc(8'h84, 32'h1, 1'b0);
        repeat (4) @(posedge pclk);
        chk("alarm_out", {28'h0, aout}, 32'h0);
        ev(120, 4'h1);
        key <= 4'h1;
        @(posedge pclk);
        key <= 4'h0;
        ev(120, 4'h0);
        $display("test latch done");
    endtask
    task t_delay;
        wrc(8'h20, 32'h0E, 1'b0);
        wrc(8'h30, 32'h2, 1'b0);
        ev(100, 4'h0);
        repeat (60) @(posedge pclk);
        ev(100, 4'h2);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("alarm_out", {28'h0, aout}, 32'h0);
        rdc(8'h2C, 32'h1);
        $display("test delay done");
    endtask
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_regs;
        t_abs;
        t_src;
        t_latch;
        t_delay;
        test_done;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        test_done;
    end
endmodule

// ==== sal_setpoint_alarm_props.sv ====
module sal_setpoint_alarm_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  alarm_out,
    input wire logic [3:0]  annunciator,
    input wire logic [2:0]  color_override
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Setup phases of transfers
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wr(ofs);
        s_setup ##0 (pwrite && !paddr[7] && paddr[4:0] == ofs);
    endsequence
    property p_err(ofs, bad);
        s_wr(ofs) |=> pslverr == bad;
    endproperty
    AST_VALUE_RANGE: assert property (p_err(sal_pkg::OFS_VALUE,
        $signed(pwdata) < sal_pkg::VALUE_MIN || $signed(pwdata) > sal_pkg::VALUE_MAX))
        else $error("value range check wrong");
    AST_BAND_RANGE: assert property (s_wr(sal_pkg::OFS_BAND) ##0
        ($signed(pwdata) > sal_pkg::VALUE_MAX) |=> pslverr) else $error("band accepted");
    AST_HYST_RANGE: assert property (p_err(sal_pkg::OFS_HYST,
        pwdata < 32'h1 || pwdata > 32'h0000FDE8)) else $error("hysteresis range wrong");
    AST_ONDLY_RANGE: assert property (p_err(sal_pkg::OFS_ONDLY,
        pwdata > 32'h00007D96)) else $error("on delay range wrong");
    AST_OFFDLY_RANGE: assert property (p_err(sal_pkg::OFS_OFFDLY,
        pwdata > 32'h00007FEE)) else $error("off delay range wrong");
    AST_UNMAPPED: assert property (s_setup ##0 (paddr[1:0] != 2'h0 || paddr > 8'h84
        || (!paddr[7] && paddr[4:3] == 2'h3)) |=> pslverr && prdata == 32'h0)
        else $error("unmapped address answered");
    AST_NO_WAIT: assert property (s_setup |=> pready) else $error("pready late");
    AST_STANDS: assert property (psel && penable |=> $stable(prdata) && $stable(pslverr))
        else $error("read data changed after access");
    AST_RESET_OFF: assert property ($rose(presetn) |->
        (alarm_out == 4'h0 && annunciator == 4'h0 && color_override == 3'h0) [*3])
        else $error("outputs not cleared after reset");
endmodule
bind sal_setpoint_alarm sal_setpoint_alarm_chk i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm_out(alarm_out),
    .annunciator(annunciator), .color_override(color_override));
